// >>> common/rcr_pkg.sv
`default_nettype none
package rcr_pkg;
	localparam logic [15:0] RCR_OFS_INDEX = 16'h0070;
	localparam logic [15:0] RCR_OFS_DATA = 16'h0071;
	localparam int RCR_RAM_BYTES = 64;
	localparam int RCR_CLOCK_BYTES = 14;
	localparam int RCR_EXT_BYTES = 2048;
	localparam int RCR_NMI_MASK_BIT = 7;
	localparam int RCR_RSVD_INDEX_BIT = 6;
	localparam int RCR_INDEX_W = 6;
	localparam int RCR_FLAG_BIT = 7;
	localparam logic [5:0] RCR_IDX_STAT_A = 6'h0a;
	localparam logic [5:0] RCR_IDX_STAT_D = 6'h0d;
	localparam logic [5:0] RCR_INDEX_RESET = 6'h0d;
	localparam logic [7:0] RCR_BYTE_RESET = 8'h00;
	localparam logic [7:0] RCR_BUS_IDLE = 8'h00;
endpackage
`default_nettype wire

// >>> rtl/rcr_indexed_access.sv
`timescale 1ns/1ns
`default_nettype none
// Operation
// - 64 RAM bytes, first 14 for clock
// - Other bytes hold last written value
// - Separate 2KB battery-backed extension RAM
// - Index bit 7 masks the NMI
// - Reset sets NMI mask to one
// - NMI mask is write-only
// - Index bits 5..0 select RAM byte
// - Data port reads/writes selected byte
// - Bytes 0..13 are time, alarm, status
// - Register D bit 7 reports power kept
// - Register A bit 7 shows update busy
module rcr_indexed_access
	import rcr_pkg::*;
#(
	parameter int RAM_BYTES = RCR_RAM_BYTES,
	parameter int EXT_BYTES = RCR_EXT_BYTES,
	parameter int EXT_AW = $clog2(EXT_BYTES)
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [15:0] ioAddr,
	input wire logic ioWrite,
	input wire logic ioRead,
	input wire logic [7:0] ioWrData,
	output logic [7:0] ioRdData,
	output logic ioRdValid,
	input wire logic powerGood,
	input wire logic updateBusy,
	output logic nmiMasked,
	input wire logic extWrite,
	input wire logic [EXT_AW-1:0] extAddr,
	input wire logic [7:0] extWrData,
	output logic [7:0] extRdData
);
	localparam int LIVE_N = 2;

	typedef struct packed {
		logic [RCR_INDEX_W-1:0] index;
		logic nmiMask;
		logic [7:0] rdData;
		logic rdValid;
		logic [7:0] extRd;
	} rcr_state_t;

	// All state but the RAM arrays, one register
	rcr_state_t state_q;
	rcr_state_t state_d;

	// Battery-backed contents are not cleared by reset
	logic [7:0] ram_q [RAM_BYTES];

	// Kept apart so the index port can never reach it
	logic [7:0] ext_q [EXT_BYTES];

	// Shared by all three port strobes
	function automatic logic isPort(
		input logic [15:0] a,
		input logic [15:0] ofs
	);
		return a == ofs;
	endfunction

	// Reserved bit and mask bit never reach the selector
	function automatic logic [RCR_INDEX_W-1:0] indexField(
		input logic [7:0] wr
	);
		return wr[RCR_INDEX_W-1:0];
	endfunction

	function automatic logic maskField(
		input logic [7:0] wr
	);
		return wr[RCR_NMI_MASK_BIT];
	endfunction

	// Guards a smaller RAM_BYTES against reads past the array
	function automatic logic inRam(
		input logic [RCR_INDEX_W-1:0] idx
	);
		return int'(idx) < RAM_BYTES;
	endfunction

	function automatic logic isClockByte(
		input logic [RCR_INDEX_W-1:0] idx
	);
		return int'(idx) < RCR_CLOCK_BYTES;
	endfunction

	logic idxWr;
	logic dataWr;
	logic dataRd;

	assign idxWr = ioWrite
		&& isPort(ioAddr, RCR_OFS_INDEX);
	assign dataWr = ioWrite
		&& isPort(ioAddr, RCR_OFS_DATA);

	// Index port reads get no answer; mask is write-only
	assign dataRd = ioRead
		&& isPort(ioAddr, RCR_OFS_DATA);

	// Live flags take the place of bit 7 in A and D
	logic [RCR_INDEX_W-1:0] liveIdx [LIVE_N];
	logic liveVal [LIVE_N];
	logic [LIVE_N-1:0] liveHit;

	assign liveIdx[0] = RCR_IDX_STAT_A;
	assign liveVal[0] = updateBusy;

	assign liveIdx[1] = RCR_IDX_STAT_D;
	assign liveVal[1] = powerGood;

	genvar g;
	generate
		for (g = 0; g < LIVE_N; g++) begin : gLive
			assign liveHit[g] = isClockByte(state_q.index)
				&& (state_q.index == liveIdx[g]);
		end
	endgenerate

	// Unwritten bytes read unknown until software sets them
	logic [7:0] rawByte;

	logic [7:0] shownByte;

	always_comb begin
		rawByte = RCR_BUS_IDLE;
		if (inRam(state_q.index)) begin
			rawByte = ram_q[state_q.index];
		end
		shownByte = rawByte;

		for (int k = 0; k < LIVE_N; k++) begin
			if (liveHit[k]) begin
				shownByte[RCR_FLAG_BIT] = liveVal[k];
			end
		end
	end

	// One enable per byte; a shrunken RAM simply drops writes
	logic [RAM_BYTES-1:0] byteWe;

	genvar b;
	generate
		for (b = 0; b < RAM_BYTES; b++) begin : gByte
			assign byteWe[b] = dataWr
				&& (state_q.index == RCR_INDEX_W'(b));
		end
	endgenerate

	// Extension has its own port; reads lag one cycle
	logic [7:0] extByte;

	always_comb begin
		extByte = ext_q[extAddr];
	end

	// Synchronous reset wins over the index and read strobes; data writes still reach the RAM
	always_comb begin
		state_d = state_q;
		if (rst) begin
			state_d.index = RCR_INDEX_RESET;
			state_d.nmiMask = 1'b1;
			state_d.rdData = RCR_BUS_IDLE;
			state_d.rdValid = 1'b0;
			state_d.extRd = RCR_BYTE_RESET;
		end else begin
			// Index stands until the next index write
			if (idxWr) begin
				state_d.index = indexField(ioWrData);
				state_d.nmiMask = maskField(ioWrData);
			end

			// Read data stands until the next data read
			state_d.rdValid = dataRd;
			if (dataRd) begin
				state_d.rdData = shownByte;
			end

			// Extension read port samples every cycle
			state_d.extRd = extByte;
		end
	end

	// No clock enable; state moves every edge
	always_ff @(posedge mclk) begin
		state_q <= state_d;
	end

	// Storage ignores reset, as the battery would
	always_ff @(posedge mclk) begin
		for (int i = 0; i < RAM_BYTES; i++) begin
			if (byteWe[i]) begin
				ram_q[i] <= ioWrData;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (extWrite) begin
			ext_q[extAddr] <= extWrData;
		end
	end

	// Outputs come straight from flip-flops
	assign ioRdData = state_q.rdData;
	assign ioRdValid = state_q.rdValid;
	assign nmiMasked = state_q.nmiMask;
	assign extRdData = state_q.extRd;
endmodule // rcr_indexed_access
`default_nettype wire

// >>> tb/rcr_host.sv
`timescale 1ns/1ns
`default_nettype none
module rcr_host(input wire logic mclk,output logic [15:0] ioAddr,
	output logic ioWrite,ioRead,output logic [7:0] ioWrData);
	initial {ioAddr,ioWrite,ioRead,ioWrData}='0;
	// Sole caller, so nothing can move the index mid-pair
	task data(input logic [7:0] d,input logic w);
		@(negedge mclk) {ioAddr,ioWrite,ioRead,ioWrData}={16'h71,w,!w,d};
		@(negedge mclk) {ioWrite,ioRead,ioWrData}={2'b00,~d};
	endtask
	task io(input logic [7:0] i,d,input logic w);
		@(negedge mclk) {ioAddr,ioWrite,ioRead,ioWrData}={16'h70,2'b10,i};
		data(d,w);
	endtask
endmodule // rcr_host
`default_nettype wire

// >>> tb/rcr_indexed_access_properties.sv
`timescale 1ns/1ns
`default_nettype none
module rcr_chk(input wire logic mclk,rst,ioWrite,ioRead,ioRdValid,nmiMasked,
	input wire logic [15:0] ioAddr,input wire logic [7:0] ioWrData,ioRdData);
	wire idxW=ioWrite&&ioAddr==16'h70;
	wire dataR=ioRead&&ioAddr==16'h71;
	default clocking @(posedge mclk); endclocking
	default disable iff rst;
	sequence indexSeq; idxW; endsequence
	sequence readSeq; dataR; endsequence
	chk_nmi_mask: assert property (indexSeq |=> nmiMasked==$past(ioWrData[7]))
		else $error("mask");
	chk_rd_valid: assert property (readSeq |=> ioRdValid)
		else $error("rd");
	chk_rd_origin: assert property (ioRdValid |-> $past(dataR))
		else $error("stray read valid");
	chk_mask_hold: assert property (!idxW |=> $stable(nmiMasked))
		else $error("mask moved");
	chk_data_hold: assert property (!dataR |=> $stable(ioRdData))
		else $error("read data moved");
	chk_pair_read: assert property (indexSeq ##1 readSeq |=> ioRdValid)
		else $error("pair read");
	chk_reset_state: assert property (disable iff (1'b0) rst |=> nmiMasked&&!ioRdValid)
		else $error("reset state");
endmodule // rcr_chk
bind rcr_indexed_access rcr_chk u_chk(.mclk(mclk),.rst(rst),.ioWrite(ioWrite),.ioRead(ioRead),
	.ioRdValid(ioRdValid),.nmiMasked(nmiMasked),.ioAddr(ioAddr),.ioWrData(ioWrData),
	.ioRdData(ioRdData));
`default_nettype wire

// >>> tb/rcr_indexed_access_bench.sv
`timescale 1ns/1ns
`default_nettype none
module rcr_indexed_access_bench;
	logic mclk=0,rst=1,powerGood=0,updateBusy=1,extWrite=0,ioWrite,ioRead,ioRdValid,nmiMasked;
	logic [15:0] ioAddr;
	logic [7:0] ioWrData,ioRdData,extRdData,extWrData=0;
	logic [10:0] extAddr=0;
	int errors,checks;
	always #2 mclk=~mclk;
	rcr_host host(.mclk(mclk),.ioAddr(ioAddr),.ioWrite(ioWrite),.ioRead(ioRead),.ioWrData(ioWrData));
	rcr_indexed_access dut(.mclk(mclk),.rst(rst),.ioAddr(ioAddr),.ioWrite(ioWrite),.ioRead(ioRead),
		.ioWrData(ioWrData),.ioRdData(ioRdData),.ioRdValid(ioRdValid),.powerGood(powerGood),
		.updateBusy(updateBusy),.nmiMasked(nmiMasked),.extWrite(extWrite),.extAddr(extAddr),
		.extWrData(extWrData),.extRdData(extRdData));
	task ck(input logic [7:0] g,e);
		checks++;
		if (g!==e) errors++;
		if (g!==e) $display("CHECK FAILED %0t %h %h",$time,g,e);
	endtask
	task t_io;
		ck(nmiMasked,8'h01);
		host.io(8'h8d,8'hff,1);
		ck(nmiMasked,8'h01);
		host.io(8'h4d,0,0);
		ck(ioRdValid,8'h01);
		ck(ioRdData,8'h7f);
		ck(nmiMasked,8'h00);
		$display("t_io done");
	endtask
	task t_ram;
		host.io(8'h0e,8'ha5,1);
		host.io(8'h00,8'h3c,1);
		host.io(8'h0e,0,0);
		ck(ioRdData,8'ha5);
		host.data(0,0);
		ck(ioRdData,8'ha5);
		host.io(8'h00,0,0);
		ck(ioRdData,8'h3c);
		$display("t_ram done");
	endtask
	task t_status;
		host.io(8'h0a,8'h7f,1);
		host.io(8'h0a,0,0);
		ck(ioRdData,8'hff);
		updateBusy=0;
		host.data(0,0);
		ck(ioRdData,8'h7f);
		powerGood=1;
		host.io(8'h0d,0,0);
		ck(ioRdData,8'hff);
		$display("t_status done");
	endtask
	task t_ext;
		@(negedge mclk) {extWrite,extAddr,extWrData}={1'b1,11'h7ff,8'h5a};
		@(negedge mclk) extWrite=0;
		@(negedge mclk) ck(extRdData,8'h5a);
		$display("t_ext done");
	endtask
	task t_reset;
		host.io(8'h0d,0,0);
		ck(nmiMasked,8'h00);
		@(negedge mclk) rst=1;
		@(negedge mclk) rst=0;
		ck(nmiMasked,8'h01);
		ck(ioRdValid,8'h00);
		host.data(0,0);
		ck(ioRdData,8'hff);
		$display("t_reset done");
	endtask
	task end_of_test;
		$display("checks %0d errors %0d",checks,errors);
		if (errors==0&&checks>0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		repeat(8) @(negedge mclk);
		rst=0;
		t_io;
		t_ram;
		t_status;
		t_ext;
		t_reset;
		end_of_test;
	end
endmodule // rcr_indexed_access_bench
`default_nettype wire
